// file: logic/mmd_pkg.sv
// Constants for the memory map decoder: register offsets, field positions,
// reset values and address region codes.
// Assumes a 24-bit byte address space and 16-bit configuration registers.
package mmd_pkg;

  // ==========================================================
  // Register offsets in I/O space
  localparam logic [7:0] OFF_MEM_CFG = 8'h22;
  localparam logic [7:0] OFF_ROLL_A = 8'h24;
  localparam logic [7:0] OFF_ROLL_B = 8'h26;
  localparam logic [7:0] OFF_RANGE_A = 8'h28;
  localparam logic [7:0] OFF_RANGE_B = 8'h2A;

  // ==========================================================
  // Memory configuration bit positions
  localparam int BIT_BIOS_SHADOW = 0;
  localparam int BIT_BASE_640 = 3;
  localparam int BIT_DRAM_TYPE = 4;
  localparam int BIT_BANK_LO = 6;
  localparam int BIT_BANK_HI = 7;
  localparam int BIT_ROM_SIZE = 8;
  localparam int BIT_ADAPTER_SHADOW = 9;
  localparam int BIT_VIDEO_SHADOW = 10;
  localparam int BIT_VIDEO_RO = 11;
  localparam int BIT_FREEZE = 15;

  // ==========================================================
  // Compare register fields
  localparam int BIT_CMP_EN = 0;
  localparam int ROLL_MASK_LO = 1;
  localparam int ROLL_MASK_HI = 7;
  localparam int ROLL_DATA_LO = 9;
  localparam int ROLL_DATA_HI = 15;
  localparam int RANGE_MASK_LO = 3;
  localparam int RANGE_MASK_HI = 7;
  localparam int RANGE_DATA_LO = 11;
  localparam int RANGE_DATA_HI = 15;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_MEM_CFG = 16'h0000;
  localparam logic [15:0] RST_ROLL = 16'h0000;
  localparam logic [15:0] RST_RANGE_A = 16'h0001;
  localparam logic [15:0] RST_RANGE_B = 16'h0000;

  // ==========================================================
  // Low megabyte segments and top ROM alias, address bits 23:17 (128K units)
  localparam logic [6:0] SEG_BASE_TOP = 7'h04;
  localparam logic [6:0] SEG_VIDEO = 7'h05;
  localparam logic [6:0] SEG_ADAPTER = 7'h06;
  localparam logic [6:0] SEG_BIOS = 7'h07;
  localparam logic [6:0] SEG_ROM_ALIAS = 7'h7F;

  // ROM 64K pages, address bits 23:16
  localparam logic [7:0] PAGE_LO_E = 8'h0E;
  localparam logic [7:0] PAGE_LO_F = 8'h0F;
  localparam logic [7:0] PAGE_HI_E = 8'hFE;
  localparam logic [7:0] PAGE_HI_F = 8'hFF;

  // Bank size in 512K units, address bits 23:19
  localparam logic [5:0] UNITS_1MBIT = 6'h04;
  localparam logic [5:0] UNITS_256K = 6'h01;

  // ==========================================================
  // Cycle tracker states
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_IO = 1'b1
  } mmd_st_type;

endpackage

// file: logic/mmd_cmp_if.sv
// Carrier between the decoder and one masked address comparator.
// Assumes the comparator is purely combinational.
`timescale 1ns/1ps
interface mmd_cmp_if #(parameter int W = 7);
  logic [W-1:0] field;
  logic [W-1:0] mask;
  logic [W-1:0] cmpData;
  logic en;
  logic hit;
  modport unit(input field, input mask, input cmpData, input en,
    output hit);
  modport user(output field, output mask, output cmpData, output en,
    input hit);
endinterface

// file: logic/mmd_match.sv
// Masked address comparator used for roll and range compares.
// Assumes the user drives all compare inputs combinationally.
`timescale 1ns/1ps
module mmd_match
(
  mmd_cmp_if.unit c
);
  // Only bits with a mask one take part
  assign c.hit = c.en && ((c.field & c.mask) == (c.cmpData & c.mask));
endmodule

// file: logic/mmd_decoder.sv
// Memory map decoder: configuration, roll and range registers in I/O
// space, shadow policy, ROM and low megabyte selects, onboard hit.
// Assumes bus inputs synchronous to clk; one cycle per ads strobe.
//
// Function
// R1 - Configuration register at 22H, reset zero
// R2 - Bit 0 shadows E0000H-FFFFFH into DRAM
// R3 - Bit 3 picks 512K or 640K base
// R4 - Bit 4 marks one-megabit DRAM parts
// R5 - Bits 7:6 count banks, 00 one, 01 two
// R6 - Bank codes 10 three, 11 four
// R7 - Bit 8 picks 256K or 512K ROM
// R8 - Bit 9 shadows C0000H-DFFFFH into DRAM
// R9 - Bit 10 shadows A0000H-BFFFFH into DRAM
// R10 - Bit 11 makes shadowed video read-only
// R11 - Unfrozen: registers decoded, no bus status
// R12 - Frozen: registers hidden, status emitted, BIOS and adapter shadow read-only
// R13 - Freeze cleared only by reset
// R14 - Every write replaces all register bits
// R15 - Roll registers at 24H, 26H with fields
// R16 - Enabled roll match on A23:17 triggers remap
// R17 - Range registers 28H, 2AH; first enabled
// R18 - Enabled range match on A23:19 marks onboard
// R19 - BIOS shadow holds both ROM selects off
// R20 - 256K ROM: split selects over two pages
// R21 - 512K ROM: select zero only
// R22 - Low megabyte select, never on I/O
// R23 - System memory: no onboard hit, no next-address
// R24 - Writes land at cycle end, none when frozen
`timescale 1ns/1ps
module mmd_decoder
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Processor bus
  input wire logic adsN,
  input wire logic [23:1] addr,
  input wire logic memIo,
  input wire logic wrRd,
  input wire logic cycleEnd,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic dataOe,
  // Decode outputs
  output logic romSel0N,
  output logic romSel1N,
  output logic lowMegSelN,
  output logic onboardMemHit,
  output logic nextAddrReqN,
  output logic rollHit,
  output logic shadowWriteBlock,
  // Bus status
  output logic busStatusZeroN,
  output logic busStatusOneN
);

  typedef struct packed
  {
    mmd_pkg::mmd_st_type st;
    logic [15:0] memCfg;
    logic [15:0] rollA;
    logic [15:0] rollB;
    logic [15:0] rangeA;
    logic [15:0] rangeB;
    logic [7:0] ioOff;
    logic ioWr;
    logic [15:0] dataOut;
    logic dataOe;
    logic romSel0N;
    logic romSel1N;
    logic lowMegSelN;
    logic onboardMemHit;
    logic nextAddrReqN;
    logic rollHit;
    logic shadowWriteBlock;
    logic statZeroN;
    logic statOneN;
  } mmd_state_type;

  mmd_state_type s;
  mmd_state_type next_s;

  // ==========================================================
  // Configuration fields
  wire logic biosSh = s.memCfg[mmd_pkg::BIT_BIOS_SHADOW]; // [R2]
  wire logic base640 = s.memCfg[mmd_pkg::BIT_BASE_640]; // [R3]
  wire logic dramType = s.memCfg[mmd_pkg::BIT_DRAM_TYPE]; // [R4]
  wire logic [1:0] bankCount =
    s.memCfg[mmd_pkg::BIT_BANK_HI:mmd_pkg::BIT_BANK_LO]; // [R5] [R6]
  wire logic rom_size_sel = s.memCfg[mmd_pkg::BIT_ROM_SIZE]; // [R7]
  wire logic adSh = s.memCfg[mmd_pkg::BIT_ADAPTER_SHADOW]; // [R8]
  wire logic vidSh = s.memCfg[mmd_pkg::BIT_VIDEO_SHADOW]; // [R9]
  wire logic vidRo = s.memCfg[mmd_pkg::BIT_VIDEO_RO]; // [R10]
  wire logic frozen = s.memCfg[mmd_pkg::BIT_FREEZE]; // [R12] [R13]

  // ==========================================================
  // Comparators
  mmd_cmp_if #(.W(7)) rollIf [2] ();
  mmd_cmp_if #(.W(5)) rangeIf [2] ();
  logic [15:0] rollReg [2];
  logic [15:0] rangeReg [2];

  assign rollReg[0] = s.rollA;
  assign rollReg[1] = s.rollB;
  assign rangeReg[0] = s.rangeA;
  assign rangeReg[1] = s.rangeB;

  for (genvar i = 0; i < 2; i++)
  begin : g_cmp
    // Roll compare on A23:17
    assign rollIf[i].field = addr[23:17]; // [R16]
    assign rollIf[i].mask =
      rollReg[i][mmd_pkg::ROLL_MASK_HI:mmd_pkg::ROLL_MASK_LO]; // [R15]
    assign rollIf[i].cmpData =
      rollReg[i][mmd_pkg::ROLL_DATA_HI:mmd_pkg::ROLL_DATA_LO]; // [R15]
    assign rollIf[i].en = rollReg[i][mmd_pkg::BIT_CMP_EN]; // [R15]
    mmd_match u_roll (.c(rollIf[i]));
    // Range compare on A23:19
    assign rangeIf[i].field = addr[23:19]; // [R18]
    assign rangeIf[i].mask =
      rangeReg[i][mmd_pkg::RANGE_MASK_HI:mmd_pkg::RANGE_MASK_LO]; // [R17]
    assign rangeIf[i].cmpData =
      rangeReg[i][mmd_pkg::RANGE_DATA_HI:mmd_pkg::RANGE_DATA_LO]; // [R17]
    assign rangeIf[i].en = rangeReg[i][mmd_pkg::BIT_CMP_EN]; // [R17]
    mmd_match u_range (.c(rangeIf[i]));
  end

  // ==========================================================
  // Address decode
  wire logic newCycle = !adsN;
  wire logic lowMeg = (addr[23:20] == 4'h0);
  wire logic [6:0] seg = addr[23:17];
  wire logic [7:0] page = addr[23:16];
  logic sel0;
  logic sel1;
  logic inHole;
  logic [5:0] dramTop;
  logic belowTop;
  wire logic rollAny = memIo && (rollIf[0].hit || rollIf[1].hit); // [R16]
  wire logic rangeAny = rangeIf[0].hit || rangeIf[1].hit; // [R18]
  logic onboard;
  logic wrBlock;
  logic [7:0] ioOff;
  logic ioInWindow;
  logic regAccess;
  logic [15:0] rdData;

  assign sel0 = memIo && !biosSh && (rom_size_sel ? // [R19] [R21]
    (seg == mmd_pkg::SEG_BIOS || seg == mmd_pkg::SEG_ROM_ALIAS) :
    (page == mmd_pkg::PAGE_LO_E || page == mmd_pkg::PAGE_HI_E)); // [R20]
  assign sel1 = memIo && !biosSh && !rom_size_sel && // [R19] [R21]
    (page == mmd_pkg::PAGE_LO_F || page == mmd_pkg::PAGE_HI_F); // [R20]

  // Low megabyte segments left out of DRAM: 512K-640K base top, video, adapter, BIOS unless enabled
  assign inHole = lowMeg &&
    ((seg == mmd_pkg::SEG_BASE_TOP && !base640) || // [R3]
    (seg == mmd_pkg::SEG_VIDEO && !vidSh) || // [R9]
    (seg == mmd_pkg::SEG_ADAPTER && !adSh) || // [R8]
    (seg == mmd_pkg::SEG_BIOS && !biosSh)); // [R2]

  // Installed DRAM top in 512K units from bank count and part type
  assign dramTop = 6'((6'(bankCount) + 6'h01) *
    (dramType ? mmd_pkg::UNITS_1MBIT : mmd_pkg::UNITS_256K)); // [R4] [R5] [R6]
  assign belowTop = ({1'b0, addr[23:19]} < dramTop);

  assign onboard = memIo && (rollAny ||
    (rangeAny && belowTop && !inHole && !sel0 && !sel1)); // [R23]

  // Shadow areas read-only once frozen; video by its own bit
  assign wrBlock = memIo && wrRd && lowMeg &&
    ((frozen && seg == mmd_pkg::SEG_BIOS && biosSh) || // [R12]
    (frozen && seg == mmd_pkg::SEG_ADAPTER && adSh) || // [R12]
    (seg == mmd_pkg::SEG_VIDEO && vidSh && vidRo)); // [R10] [R12]

  assign ioOff = {addr[7:1], 1'b0};
  assign ioInWindow = !memIo && (addr[15:8] == 8'h00) &&
    (ioOff >= mmd_pkg::OFF_MEM_CFG) && (ioOff <= mmd_pkg::OFF_RANGE_B);
  assign regAccess = ioInWindow && !frozen; // [R11] [R12]

  always_comb
  begin
    unique case (ioOff)
      mmd_pkg::OFF_MEM_CFG: rdData = s.memCfg;
      mmd_pkg::OFF_ROLL_A: rdData = s.rollA;
      mmd_pkg::OFF_ROLL_B: rdData = s.rollB;
      mmd_pkg::OFF_RANGE_A: rdData = s.rangeA;
      mmd_pkg::OFF_RANGE_B: rdData = s.rangeB;
      default: rdData = 16'h0000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    // Status ends with the bus cycle
    if (cycleEnd)
    begin
      next_s.statZeroN = 1'b1;
      next_s.statOneN = 1'b1;
    end
    unique case (s.st)
      mmd_pkg::ST_IDLE:
      begin
        if (newCycle)
        begin
          next_s.romSel0N = !sel0; // [R19] [R20] [R21]
          next_s.romSel1N = !sel1; // [R19] [R20] [R21]
          next_s.lowMegSelN = !(memIo && lowMeg); // [R22]
          next_s.onboardMemHit = onboard; // [R23]
          next_s.nextAddrReqN = !onboard; // [R23]
          next_s.rollHit = rollAny; // [R16]
          next_s.shadowWriteBlock = wrBlock;
          // Status for system memory and foreign I/O only
          next_s.statZeroN = onboard || regAccess || !wrRd; // [R11] [R12]
          next_s.statOneN = onboard || regAccess || wrRd; // [R11] [R12]
          if (regAccess)
          begin
            next_s.st = mmd_pkg::ST_IO;
            next_s.ioOff = ioOff;
            next_s.ioWr = wrRd;
            next_s.dataOut = rdData;
            next_s.dataOe = !wrRd;
          end
        end
      end
      mmd_pkg::ST_IO:
      begin
        if (cycleEnd)
        begin
          next_s.st = mmd_pkg::ST_IDLE;
          next_s.dataOe = 1'b0;
          if (s.ioWr) // [R24]
          begin
            // Whole word replaced, no merge
            unique case (s.ioOff) // [R14]
              mmd_pkg::OFF_MEM_CFG: next_s.memCfg = dataIn; // [R1]
              mmd_pkg::OFF_ROLL_A: next_s.rollA = dataIn; // [R15]
              mmd_pkg::OFF_ROLL_B: next_s.rollB = dataIn; // [R15]
              mmd_pkg::OFF_RANGE_A: next_s.rangeA = dataIn; // [R17]
              mmd_pkg::OFF_RANGE_B: next_s.rangeB = dataIn; // [R17]
              default: next_s.memCfg = s.memCfg;
            endcase
          end
        end
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.st <= mmd_pkg::ST_IDLE;
      s.memCfg <= mmd_pkg::RST_MEM_CFG; // [R1] [R13]
      s.rollA <= mmd_pkg::RST_ROLL;
      s.rollB <= mmd_pkg::RST_ROLL;
      s.rangeA <= mmd_pkg::RST_RANGE_A; // [R17]
      s.rangeB <= mmd_pkg::RST_RANGE_B; // [R17]
      s.romSel0N <= 1'b1;
      s.romSel1N <= 1'b1;
      s.lowMegSelN <= 1'b1;
      s.nextAddrReqN <= 1'b1;
      s.statZeroN <= 1'b1;
      s.statOneN <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dataOut = s.dataOut;
  assign dataOe = s.dataOe;
  assign romSel0N = s.romSel0N;
  assign romSel1N = s.romSel1N;
  assign lowMegSelN = s.lowMegSelN;
  assign onboardMemHit = s.onboardMemHit;
  assign nextAddrReqN = s.nextAddrReqN;
  assign rollHit = s.rollHit;
  assign shadowWriteBlock = s.shadowWriteBlock;
  assign busStatusZeroN = s.statZeroN;
  assign busStatusOneN = s.statOneN;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_take_io;
    s.st == mmd_pkg::ST_IDLE && newCycle && regAccess;
  endsequence

  sequence s_end_write;
    s.st == mmd_pkg::ST_IO && s.ioWr && cycleEnd;
  endsequence

  a_freeze_sticky: assert property (frozen |=> frozen) // [R13]
    else $error("freeze bit cleared without reset");
  a_frozen_hold: assert property (frozen |=> $stable(s.memCfg) &&
    $stable(s.rollA) && $stable(s.rollB) && $stable(s.rangeA) &&
    $stable(s.rangeB)) // [R24]
    else $error("register changed while frozen");
  a_cfg_write: assert property (s_end_write ##0
    (s.ioOff == mmd_pkg::OFF_MEM_CFG) |=> s.memCfg == $past(dataIn)) // [R14]
    else $error("configuration write not taken whole");
  a_reg_nostatus: assert property (s_take_io |=>
    busStatusZeroN && busStatusOneN ##1 s.st == mmd_pkg::ST_IO) // [R11]
    else $error("bus status on register access");
  a_frozen_status: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    ioInWindow && frozen |=> !(busStatusZeroN && busStatusOneN)) // [R12]
    else $error("no bus status for frozen register window");
  a_bios_romoff: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    biosSh |=> romSel0N && romSel1N) // [R19]
    else $error("ROM select while BIOS shadowed");
  a_rom512_sel1: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    rom_size_sel && memIo |=> romSel1N) // [R21]
    else $error("second ROM select with large ROM");
  a_lowmeg_io: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    !memIo |=> lowMegSelN) // [R22]
    else $error("low megabyte select on I/O cycle");
  a_na_pair: assert property (onboardMemHit == !nextAddrReqN) // [R23]
    else $error("next address and onboard hit disagree");
  a_rom_hole: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    memIo && lowMeg && seg == mmd_pkg::SEG_BIOS && !biosSh && !rollAny
    |=> !onboardMemHit) // [R2]
    else $error("unshadowed BIOS area hit DRAM");
  a_video_ro: assert property (s.st == mmd_pkg::ST_IDLE && newCycle &&
    memIo && wrRd && lowMeg && seg == mmd_pkg::SEG_VIDEO && vidSh && vidRo
    |=> shadowWriteBlock) // [R10]
    else $error("write allowed to read-only video shadow");

endmodule

// file: sim/mmd_bus_master.sv
// Processor bus master model: one memory or I/O cycle per call of run.
// Assumes the decoder samples its bus inputs on the rising edge of clk.
`timescale 1ns/1ps
module mmd_bus_master
(
  // Clock
  input wire logic clk,
  // Request side
  output logic adsN,
  output logic [23:1] addr,
  output logic memIo,
  output logic wrRd,
  output logic cycleEnd,
  output logic [15:0] dataIn,
  // Observed answer
  input wire logic [15:0] dataOut,
  input wire logic dataOe,
  input wire logic [1:0] status
);
  initial
  begin
    adsN = 1'b1;
    addr = 23'h000000;
    memIo = 1'b1;
    wrRd = 1'b0;
    cycleEnd = 1'b0;
    dataIn = 16'h0000;
  end

  // ==========================================================
  // One bus cycle, waits sets how slowly it ends
  task automatic run(input logic mem, input logic wr,
    input logic [23:0] a, input logic [15:0] wd, input int waits,
    output logic [15:0] rd, output logic oe, output logic [1:0] st);
    @(posedge clk);
    adsN <= 1'b0;
    memIo <= mem;
    wrRd <= wr;
    addr <= a[23:1];
    @(posedge clk);
    adsN <= 1'b1;
    #1;
    rd = dataOut;
    oe = dataOe;
    st = status;
    repeat (waits) @(posedge clk);
    @(posedge clk);
    cycleEnd <= 1'b1;
    dataIn <= wd; // Whole word on every write
    @(posedge clk);
    cycleEnd <= 1'b0;
    // Released lines show changing values
    addr <= ~addr;
    dataIn <= ~wd;
  endtask
endmodule

// file: sim/memory_map_decoder_tb_top.sv
// Self-checking bench for the memory map decoder.
// Assumes mmd_pkg, mmd_decoder and mmd_bus_master are compiled first.
`timescale 1ns/1ps
module memory_map_decoder_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic adsN, memIo, wrRd, cycleEnd, dataOe, oe, lastWr;
  logic romSel0N, romSel1N, lowMegSelN, onboardMemHit;
  logic nextAddrReqN, rollHit, shadowWriteBlock;
  logic busStatusZeroN, busStatusOneN;
  logic [23:1] addr;
  logic [15:0] dataIn, dataOut, rd;
  logic [1:0] st;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, timeout and instances
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      give_verdict;
    end
  end
  mmd_decoder mmd_decoder_i (.clk, .arst_n, .adsN, .addr, .memIo, .wrRd,
    .cycleEnd, .dataIn, .dataOut, .dataOe, .romSel0N, .romSel1N,
    .lowMegSelN, .onboardMemHit, .nextAddrReqN, .rollHit,
    .shadowWriteBlock, .busStatusZeroN, .busStatusOneN);
  mmd_bus_master mmd_bus_master_i (.clk, .adsN, .addr, .memIo, .wrRd,
    .cycleEnd, .dataIn, .dataOut, .dataOe,
    .status({busStatusZeroN, busStatusOneN}));

  // ==========================================================
  // Shared helpers
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic acc(input logic mem, input logic wr,
    input logic [23:0] a, input logic [15:0] wd);
    mmd_bus_master_i.run(mem, wr, a, wd, n_compared % 3, rd, oe, st);
  endtask
  task automatic wreg(input logic [7:0] off, input logic [15:0] v);
    acc(1'b0, 1'b1, {16'h0000, off}, v);
  endtask
  task automatic rreg(input logic [7:0] off);
    acc(1'b0, 1'b0, {16'h0000, off}, 16'h0000);
  endtask
  task automatic mem(input logic [23:0] a, input logic wr);
    lastWr = wr;
    acc(1'b1, wr, a, 16'h0000);
  endtask
  function automatic logic [15:0] dec();
    return {10'h000, busStatusZeroN, busStatusOneN, onboardMemHit,
      nextAddrReqN, shadowWriteBlock, rollHit};
  endfunction
  // Expected decode from hit, block, roll; status only off board
  function automatic logic [15:0] ex(input logic [2:0] e);
    return {10'h000, e[2] | ~lastWr, e[2] | lastWr, e[2], ~e[2], e[1:0]};
  endfunction
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_regs;
    logic [7:0] offs [5] = '{8'h22, 8'h24, 8'h26, 8'h28, 8'h2A};
    logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001,
      16'h0000};
    logic [15:0] wv [5] = '{16'h7BDA, 16'hA5A4, 16'h5A5B, 16'h1234,
      16'hFFFE};
    foreach (offs[i])
    begin
      rreg(offs[i]);
      chk("reset value", rv[i], rd);
      chk("read state", 16'h0007, {13'h0000, oe, st});
      wreg(offs[i], wv[i]);
      chk("write status", 16'h0003, {14'h0000, st});
      rreg(offs[i]);
      chk("written value", wv[i], rd);
      wreg(offs[i], rv[i]);
      rreg(offs[i]);
      chk("rewritten value", rv[i], rd);
    end
    acc(1'b0, 1'b0, 24'h000060, 16'h0000);
    chk("other io", 16'h0006, {13'h0000, lowMegSelN, st});
  endtask

  task automatic s_rom;
    logic [7:0] pg;
    logic s0, s1;
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'h22, {7'h00, c[1], 7'h00, c[0]});
      for (int p = 0; p < 4; p++)
      begin
        pg = {p[1] ? 4'h0 : 4'hF, 3'h7, p[0]};
        mem({pg, 16'h0000}, 1'b0);
        s0 = c[0] | (~c[1] & p[0]);
        s1 = c[0] | c[1] | ~p[0];
        chk("rom sel", {13'h0000, s0, s1, ~p[1]},
          {13'h0000, romSel0N, romSel1N, lowMegSelN});
        chk("rom decode", ex(3'h0), dec());
      end
    end
  endtask

  task automatic s_roll;
    wreg(8'h22, 16'h0000);
    wreg(8'h24, 16'h20FD);
    wreg(8'h26, 16'h20FF);
    mem(24'h200000, 1'b0);
    chk("roll exact", ex(3'h5), dec());
    mem(24'h220000, 1'b1);
    chk("roll masked", ex(3'h5), dec());
    mem(24'h240000, 1'b0);
    chk("roll miss", ex(3'h0), dec());
    wreg(8'h24, 16'h20FC);
    wreg(8'h26, 16'h20FE);
    mem(24'h200000, 1'b0);
    chk("roll off", ex(3'h0), dec());
    mem(24'h040000, 1'b0);
    chk("small dram", ex(3'h4), dec());
  endtask

  task automatic s_range;
    logic [23:0] top;
    for (int b = 0; b < 4; b++)
    begin
      top = 24'((b + 1) * 24'h200000);
      wreg(8'h22, {8'h00, b[1:0], 6'h10});
      mem(top - 24'h080000, 1'b0);
      chk("bank hit", ex(3'h4), dec());
      mem(top, 1'b1);
      chk("bank miss", ex(3'h0), dec());
    end
    wreg(8'h22, 16'h0010);
    mem(24'h090000, 1'b0);
    chk("512K base", ex(3'h0), dec());
    wreg(8'h22, 16'h0018);
    mem(24'h090000, 1'b0);
    chk("640K base", ex(3'h4), dec());
    wreg(8'h28, 16'h0000);
    wreg(8'h2A, 16'h10F9);
    mem(24'h100000, 1'b0);
    chk("range hit", ex(3'h4), dec());
    mem(24'h180000, 1'b0);
    chk("range miss", ex(3'h0), dec());
    wreg(8'h28, 16'h0001);
    wreg(8'h2A, 16'h0000);
  endtask

  task automatic s_shadow;
    logic [15:0] cf [7] = '{16'h0018, 16'h0418, 16'h0C18, 16'h0018,
      16'h0218, 16'h0018, 16'h0019};
    logic [23:0] ad [7] = '{24'h0A0000, 24'h0A0000, 24'h0A0000,
      24'h0C0000, 24'h0C0000, 24'h0E0000, 24'h0E0000};
    logic [2:0] e [7] = '{3'h0, 3'h4, 3'h6, 3'h0, 3'h4, 3'h0, 3'h4};
    foreach (cf[i])
    begin
      wreg(8'h22, cf[i]);
      mem(ad[i], 1'b1);
      chk("shadow", ex(e[i]), dec());
    end
  endtask

  task automatic s_freeze;
    wreg(8'h22, 16'h8618);
    mem(24'h0C0000, 1'b1);
    chk("frozen adapter", ex(3'h6), dec());
    mem(24'h0A0000, 1'b1);
    chk("frozen video", ex(3'h4), dec());
    rreg(8'h22);
    chk("frozen read", 16'h0002, {13'h0000, oe, st});
    wreg(8'h22, 16'h0000);
    chk("frozen write", 16'h0001, {14'h0000, st});
    wreg(8'h24, 16'h20FF);
    mem(24'h200000, 1'b1);
    chk("ignored roll", ex(3'h0), dec());
    mem(24'h0C0000, 1'b1);
    chk("still frozen", ex(3'h6), dec());
    do_reset;
    rreg(8'h22);
    chk("config after reset", 16'h0000, rd);
    chk("open again", 16'h0007, {13'h0000, oe, st});
  endtask

  // ==========================================================
  // Main sequence and verdict
  task automatic give_verdict;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    do_reset;
    s_regs;
    s_rom;
    s_roll;
    s_range;
    s_shadow;
    s_freeze;
    give_verdict;
  end
endmodule
